/* File: common/spr_regs_pkg.sv */
package spr_regs_pkg;

   // Register addresses on the serial I/O instruction byte
   localparam logic [7:0] ADDR_PHASE = 8'h08;
   localparam logic [7:0] ADDR_AMP = 8'h09;
   localparam logic [7:0] ADDR_SYNC = 8'h0a;
   localparam logic [7:0] ADDR_LIMIT = 8'h0b;

   // Widths of each register
   localparam int PHASE_W = 16;
   localparam int AMP_W = 32;
   localparam int SYNC_W = 32;
   localparam int LIMIT_W = 64;
   localparam int DATA_W = 64;

   // Amplitude register fields
   localparam int AMP_RATE_MSB = 31;
   localparam int AMP_RATE_LSB = 16;
   localparam int AMP_SCALE_MSB = 15;
   localparam int AMP_SCALE_LSB = 2;
   localparam int AMP_STEP_MSB = 1;
   localparam int AMP_STEP_LSB = 0;

   // Sync register fields
   localparam int SYNC_VAL_MSB = 31;
   localparam int SYNC_VAL_LSB = 28;
   localparam int SYNC_RX_BIT = 27;
   localparam int SYNC_GEN_BIT = 26;
   localparam int SYNC_POL_BIT = 25;
   localparam int SYNC_PRE_MSB = 23;
   localparam int SYNC_PRE_LSB = 18;
   localparam int SYNC_ODLY_MSB = 15;
   localparam int SYNC_ODLY_LSB = 11;
   localparam int SYNC_IDLY_MSB = 7;
   localparam int SYNC_IDLY_LSB = 3;
   // Bits that hold storage; all others read as zero
   localparam logic [31:0] SYNC_MASK = 32'hfefcf8f8;

   // Ramp limit fields
   localparam int LIM_UP_MSB = 63;
   localparam int LIM_UP_LSB = 32;
   localparam int LIM_LO_MSB = 31;
   localparam int LIM_LO_LSB = 0;

   // Reset values
   localparam logic [15:0] PHASE_RST = 16'h0000;
   localparam logic [31:0] AMP_RST = 32'h00000000;
   localparam logic [31:0] SYNC_RST = 32'h00000000;
   localparam logic [63:0] LIMIT_RST = 64'h0000000000000000;

   // Output keying mode that lets the ramp fields act
   localparam logic [1:0] KEY_AUTO = 2'h3;

endpackage

/* File: verilog/spr_field_gate.sv */
`timescale 1ns/1ps
`default_nettype none
// Registered gate: passes a stored field only while its feature is enabled
module spr_field_gate #(
   parameter int W = 8
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire logic [W-1:0] value_in,
   output logic [W-1:0] value_out
);

   wire [W-1:0] value_next = enable_in ? value_in : '0;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         value_out <= '0;
      end else begin
         value_out <= value_next;
      end
   end

endmodule
`default_nettype wire

/* File: verilog/spr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Phase offset register holds 16-bit phase offset, driven to the core.
// - Amplitude register bits 15:2 hold the 14-bit amplitude scale.
// - Amplitude bits 31:16 ramp rate acts only when keying mode is 11.
// - Amplitude bits 1:0 step size acts only when keying mode is 11.
// - Sync bits 31:28 set validation skew in ~150 ps steps; reset zero.
// - Sync bit 27 enables sync receiver; reset zero, disabled.
// - Sync bit 26 enables sync generator; reset zero, disabled.
// - Sync bit 25 picks generator edge: 0 rising (default), 1 falling.
// - On a sync pulse the clock generator loads 6-bit preset, bits 23:18.
// - Sync bits 15:11 set generator output delay; reset zero.
// - Sync bits 7:3 set receiver input delay; reset zero.
// - Ramp limit register acts only while ramp enable is set.
// - Ramp limit holds upper limit in 63:32, lower limit in 31:0.
module spr_regs
   import spr_regs_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   output logic [DATA_W-1:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire logic [1:0] output_keying_mode_in,
   input wire logic ramp_enable_in,
   input wire logic sync_pulse_in,
   output logic [PHASE_W-1:0] phase_offset_out,
   output logic [13:0] amp_scale_out,
   output logic [15:0] amp_ramp_rate_out,
   output logic [1:0] amp_step_out,
   output logic [3:0] sync_valid_delay_out,
   output logic sync_rx_en_out,
   output logic sync_gen_en_out,
   output logic sync_gen_pol_out,
   output logic [5:0] sync_preset_out,
   output logic [4:0] sync_out_delay_out,
   output logic [4:0] sync_in_delay_out,
   output logic sync_state_load_out,
   output logic [5:0] sync_state_out,
   output logic [31:0] ramp_upper_out,
   output logic [31:0] ramp_lower_out
);

   ////////////////////////////////////////////////////////////////////////
   // Storage

   logic [PHASE_W-1:0] phase_reg;
   logic [AMP_W-1:0] amp_reg;
   logic [SYNC_W-1:0] sync_reg;
   logic [LIMIT_W-1:0] limit_reg;

   wire wr_phase = reg_wr_in && (reg_addr_in == ADDR_PHASE);
   wire wr_amp = reg_wr_in && (reg_addr_in == ADDR_AMP);
   wire wr_sync = reg_wr_in && (reg_addr_in == ADDR_SYNC);
   wire wr_limit = reg_wr_in && (reg_addr_in == ADDR_LIMIT);

   // Only bits that exist are stored, so reserved bits can never read back
   wire [SYNC_W-1:0] sync_wr_val = reg_wdata_in[SYNC_W-1:0] & SYNC_MASK;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         phase_reg <= PHASE_RST;
         amp_reg <= AMP_RST;
         sync_reg <= SYNC_RST;
         limit_reg <= LIMIT_RST;
      end else begin
         if (wr_phase) begin
            phase_reg <= reg_wdata_in[PHASE_W-1:0];
         end
         if (wr_amp) begin
            amp_reg <= reg_wdata_in[AMP_W-1:0];
         end
         if (wr_sync) begin
            sync_reg <= sync_wr_val;
         end
         if (wr_limit) begin
            limit_reg <= reg_wdata_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port: one cycle latency, unmapped addresses return zero

   wire [DATA_W-1:0] rd_mux =
      (reg_addr_in == ADDR_PHASE) ? {48'h0, phase_reg} :
      (reg_addr_in == ADDR_AMP) ? {32'h0, amp_reg} :
      (reg_addr_in == ADDR_SYNC) ? {32'h0, sync_reg} :
      (reg_addr_in == ADDR_LIMIT) ? limit_reg : 64'h0;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 64'h0;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rdata_out <= reg_rd_in ? rd_mux : 64'h0;
         reg_rvalid_out <= reg_rd_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Direct field outputs, one register stage after storage

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         phase_offset_out <= PHASE_RST;
         amp_scale_out <= '0;
         sync_valid_delay_out <= '0;
         sync_rx_en_out <= 1'b0;
         sync_gen_en_out <= 1'b0;
         sync_gen_pol_out <= 1'b0;
         sync_preset_out <= '0;
         sync_out_delay_out <= '0;
         sync_in_delay_out <= '0;
      end else begin
         phase_offset_out <= phase_reg;
         amp_scale_out <= amp_reg[AMP_SCALE_MSB:AMP_SCALE_LSB];
         sync_valid_delay_out <= sync_reg[SYNC_VAL_MSB:SYNC_VAL_LSB];
         sync_rx_en_out <= sync_reg[SYNC_RX_BIT];
         sync_gen_en_out <= sync_reg[SYNC_GEN_BIT];
         sync_gen_pol_out <= sync_reg[SYNC_POL_BIT];
         sync_preset_out <= sync_reg[SYNC_PRE_MSB:SYNC_PRE_LSB];
         sync_out_delay_out <= sync_reg[SYNC_ODLY_MSB:SYNC_ODLY_LSB];
         sync_in_delay_out <= sync_reg[SYNC_IDLY_MSB:SYNC_IDLY_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sync preset load; the pulse comes from on-chip logic on this clock

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sync_state_load_out <= 1'b0;
         sync_state_out <= '0;
      end else begin
         sync_state_load_out <= sync_pulse_in;
         if (sync_pulse_in) begin
            sync_state_out <= sync_reg[SYNC_PRE_MSB:SYNC_PRE_LSB];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gated fields: zero while their feature is off, so the engines
   // downstream never see stale settings

   wire keying_auto = (output_keying_mode_in == KEY_AUTO);

   spr_field_gate #(.W(18)) u_amp_gate (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .enable_in(keying_auto),
      .value_in({amp_reg[AMP_RATE_MSB:AMP_RATE_LSB],
                 amp_reg[AMP_STEP_MSB:AMP_STEP_LSB]}),
      .value_out({amp_ramp_rate_out, amp_step_out})
   );

   spr_field_gate #(.W(LIMIT_W)) u_limit_gate (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .enable_in(ramp_enable_in),
      .value_in({limit_reg[LIM_UP_MSB:LIM_UP_LSB],
                 limit_reg[LIM_LO_MSB:LIM_LO_LSB]}),
      .value_out({ramp_upper_out, ramp_lower_out})
   );

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_phase;
      @(posedge clk_sys_in) disable iff (rst_in)
      wr_phase |=> ##1
         phase_offset_out == $past(reg_wdata_in[PHASE_W-1:0], 2);
   endproperty
   a_phase: assert property (p_phase) else $error("phase offset lost");

   property p_scale;
      @(posedge clk_sys_in) disable iff (rst_in)
      wr_amp |=> ##1 amp_scale_out ==
         $past(reg_wdata_in[AMP_SCALE_MSB:AMP_SCALE_LSB], 2);
   endproperty
   a_scale: assert property (p_scale) else $error("amp scale lost");

   property p_rate_on;
      @(posedge clk_sys_in) disable iff (rst_in)
      keying_auto |=>
         amp_ramp_rate_out == $past(amp_reg[AMP_RATE_MSB:AMP_RATE_LSB]);
   endproperty
   a_rate_on: assert property (p_rate_on) else $error("ramp rate wrong");

   property p_step_off;
      @(posedge clk_sys_in) disable iff (rst_in)
      !keying_auto |=> amp_step_out == 2'h0 && amp_ramp_rate_out == 16'h0;
   endproperty
   a_step_off: assert property (p_step_off) else $error("step leaks");

   property p_sync_fields;
      @(posedge clk_sys_in) disable iff (rst_in)
      wr_sync |=> ##1
         sync_valid_delay_out ==
            $past(reg_wdata_in[SYNC_VAL_MSB:SYNC_VAL_LSB], 2)
         && sync_out_delay_out ==
            $past(reg_wdata_in[SYNC_ODLY_MSB:SYNC_ODLY_LSB], 2)
         && sync_in_delay_out ==
            $past(reg_wdata_in[SYNC_IDLY_MSB:SYNC_IDLY_LSB], 2);
   endproperty
   a_sync_fields: assert property (p_sync_fields) else $error("delay bad");

   property p_sync_en;
      @(posedge clk_sys_in) disable iff (rst_in)
      wr_sync |=> ##1 sync_rx_en_out == $past(reg_wdata_in[SYNC_RX_BIT], 2)
         && sync_gen_en_out == $past(reg_wdata_in[SYNC_GEN_BIT], 2);
   endproperty
   a_sync_en: assert property (p_sync_en) else $error("enable bad");

   property p_pol;
      @(posedge clk_sys_in) disable iff (rst_in)
      wr_sync |=> ##1
         sync_gen_pol_out == $past(reg_wdata_in[SYNC_POL_BIT], 2);
   endproperty
   a_pol: assert property (p_pol) else $error("polarity bad");

   property p_preset;
      @(posedge clk_sys_in) disable iff (rst_in)
      sync_pulse_in |=> sync_state_load_out
         && sync_state_out == $past(sync_reg[SYNC_PRE_MSB:SYNC_PRE_LSB]);
   endproperty
   a_preset: assert property (p_preset) else $error("preset not loaded");

   property p_ramp_off;
      @(posedge clk_sys_in) disable iff (rst_in)
      !ramp_enable_in |=> ramp_upper_out == 32'h0 && ramp_lower_out == 32'h0;
   endproperty
   a_ramp_off: assert property (p_ramp_off) else $error("limit leaks");

   property p_ramp_on;
      @(posedge clk_sys_in) disable iff (rst_in)
      ramp_enable_in |=>
         ramp_upper_out == $past(limit_reg[LIM_UP_MSB:LIM_UP_LSB])
         && ramp_lower_out == $past(limit_reg[LIM_LO_MSB:LIM_LO_LSB]);
   endproperty
   a_ramp_on: assert property (p_ramp_on) else $error("limit wrong");

   property p_reserved;
      @(posedge clk_sys_in) disable iff (rst_in)
      reg_rd_in && reg_addr_in == ADDR_SYNC
         |=> (reg_rdata_out & ~{32'h0, SYNC_MASK}) == 64'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved set");

   c_keying: cover property (@(posedge clk_sys_in) wr_amp ##1 keying_auto);
   c_ramp: cover property (@(posedge clk_sys_in) wr_limit ##1 ramp_enable_in);
   c_sync: cover property (@(posedge clk_sys_in) wr_sync ##[1:4] sync_pulse_in);
   c_read: cover property (@(posedge clk_sys_in) reg_rd_in ##1 reg_rvalid_out);

endmodule
`default_nettype wire

/* File: testbench/spr_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port: one whole access per call
module spr_host
   import spr_regs_pkg::*;
(
   input wire logic clk_sys_in,
   output logic [7:0] addr_out,
   output logic wr_out,
   output logic rd_out,
   output logic [DATA_W-1:0] wdata_out,
   input wire logic [DATA_W-1:0] rdata_in,
   input wire logic rvalid_in
);
   initial begin
      addr_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 64'h0;
   end
   // Idle lines are inverted so a stale address or data cannot pass
   task automatic idle();
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = ~addr_out;
      wdata_out = ~wdata_out;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [63:0] d);
      @(negedge clk_sys_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge clk_sys_in);
      idle();
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [63:0] d,
                         output logic ok);
      @(negedge clk_sys_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge clk_sys_in);
      // Answer stands only for the cycle after the taking edge
      ok = rvalid_in;
      d = rdata_in;
      idle();
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import spr_regs_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr;
   logic wr, rd, rvalid, rx, gen, pol, load;
   logic [63:0] wdata, rdata;
   logic [1:0] mode = 2'h0;
   logic ramp_en = 1'b0;
   logic pulse = 1'b0;
   logic [15:0] ph, rate;
   logic [13:0] scale;
   logic [1:0] step;
   logic [3:0] vdly;
   logic [5:0] pre, state;
   logic [4:0] odly, idly;
   logic [31:0] up, lo;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   always #2.5 clk_sys_in = ~clk_sys_in;
   spr_host host (.clk_sys_in(clk_sys_in), .addr_out(addr), .wr_out(wr),
      .rd_out(rd), .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
   spr_regs dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .output_keying_mode_in(mode), .ramp_enable_in(ramp_en),
      .sync_pulse_in(pulse), .phase_offset_out(ph), .amp_scale_out(scale),
      .amp_ramp_rate_out(rate), .amp_step_out(step),
      .sync_valid_delay_out(vdly), .sync_rx_en_out(rx),
      .sync_gen_en_out(gen), .sync_gen_pol_out(pol),
      .sync_preset_out(pre), .sync_out_delay_out(odly),
      .sync_in_delay_out(idly), .sync_state_load_out(load),
      .sync_state_out(state), .ramp_upper_out(up), .ramp_lower_out(lo));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [63:0] exp);
      logic [63:0] v;
      logic ok;
      host.rd_reg(a, v, ok);
      chk({63'h0, ok}, 64'h1);
      chk(v, exp);
   endtask
   task automatic w2();
      repeat (2) @(negedge clk_sys_in);
   endtask
   // Field outputs packed back into register layout
   function automatic logic [63:0] sync_view();
      return {32'h0, vdly, rx, gen, pol, 1'b0, pre, 2'h0, odly, 3'h0,
              idly, 3'h0};
   endfunction
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(sync_view(), 64'h0);
      rchk(ADDR_AMP, 64'h0);
      rchk(ADDR_LIMIT, 64'h0);
   endtask
   task automatic t_phase();
      host.wr_reg(ADDR_PHASE, 64'hffffffffffff1234);
      w2();
      chk({48'h0, ph}, 64'h1234);
      rchk(ADDR_PHASE, 64'h1234);
   endtask
   task automatic t_amp();
      host.wr_reg(ADDR_AMP, 64'ha5a5c3c7);
      w2();
      chk({50'h0, scale}, 64'h30f1);
      chk({46'h0, rate, step}, 64'h0);
      mode = 2'h2;
      w2();
      chk({46'h0, rate, step}, 64'h0);
      mode = KEY_AUTO;
      w2();
      chk({46'h0, rate, step}, 64'h29697);
      mode = 2'h0;
      w2();
      chk({46'h0, rate, step}, 64'h0);
      rchk(ADDR_AMP, 64'ha5a5c3c7);
   endtask
   task automatic t_sync();
      host.wr_reg(ADDR_SYNC, 64'hffffffff);
      w2();
      rchk(ADDR_SYNC, 64'hfefcf8f8);
      host.wr_reg(ADDR_SYNC, 64'h9a5c4850);
      w2();
      chk(sync_view(), 64'h9a5c4850);
      @(negedge clk_sys_in);
      pulse = 1'b1;
      @(negedge clk_sys_in);
      chk({57'h0, load, state}, 64'h57);
      pulse = 1'b0;
      @(negedge clk_sys_in);
      chk({57'h0, load, state}, 64'h17);
      host.wr_reg(ADDR_SYNC, 64'h0);
      w2();
      chk({57'h0, load, state}, 64'h17);
      chk(sync_view(), 64'h0);
   endtask
   task automatic t_limit();
      host.wr_reg(ADDR_LIMIT, 64'h89abcdef01234567);
      w2();
      chk({up, lo}, 64'h0);
      ramp_en = 1'b1;
      w2();
      chk({up, lo}, 64'h89abcdef01234567);
      host.wr_reg(8'h0c, 64'h1);
      rchk(8'h0c, 64'h0);
      rchk(ADDR_LIMIT, 64'h89abcdef01234567);
      ramp_en = 1'b0;
      w2();
      chk({up, lo}, 64'h0);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Whole run needs about 60 cycles; the ceiling leaves margin
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (3) @(negedge clk_sys_in);
      rst_in = 1'b0;
      t_reset();
      t_phase();
      t_amp();
      t_sync();
      t_limit();
      conclude();
   end
endmodule
`default_nettype wire
